// *** edge_count_led_current_ctrl_tb_top.sv ***
// testbench joining host and device ends of the edge-count link
`timescale 1ns/1ps
module edge_count_led_current_ctrl_tb_top;
  import led_link_pkg::*;
  localparam int unsigned FL_CYC = 200;
  // shortened device timers keep the run short; host holds stay longer than them
  localparam int unsigned DEV_LATCH = 20;
  localparam int unsigned DEV_OFF = 40;
  localparam int unsigned HOST_PHASE = 3;
  localparam int unsigned HOST_HOLD = 30;
  localparam int unsigned HOST_OFF = 60;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_cap_grounded = 1'b0;
  logic [SINKS-1:0] backlight_sink_at_pump = 4'h0;
  logic [SINKS-1:0] flash_sink_at_pump = 4'h0;
  logic req_valid = 1'b0;
  logic req_flash = 1'b0;
  logic req_shutdown = 1'b0;
  code_t req_code = 5'h00;
  code_t backlight_code;
  code_t flash_code;
  logic [SINKS-1:0] backlight_sinks;
  logic [SINKS-1:0] flash_sinks;
  logic flash_timer_run;
  logic shutdown;
  logic busy;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  led_link_if u_led_link_if();
  led_link_device #(
    .LATCH_CYC(DEV_LATCH), .OFF_CYC(DEV_OFF), .FLASH_CYC(FL_CYC)) u_led_link_device (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(u_led_link_if),
    .timer_cap_grounded(timer_cap_grounded), .backlight_sink_at_pump(backlight_sink_at_pump),
    .flash_sink_at_pump(flash_sink_at_pump), .backlight_code(backlight_code),
    .flash_code(flash_code), .backlight_sinks(backlight_sinks), .flash_sinks(flash_sinks),
    .flash_timer_run(flash_timer_run), .shutdown(shutdown));
  // 3-cycle phases give edges above 1 MHz; host holds exceed device timers
  led_link_host #(
    .PHASE_CYC(HOST_PHASE), .LATCH_CYC(HOST_HOLD), .OFF_CYC(HOST_OFF)) u_led_link_host (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(u_led_link_if), .req_valid(req_valid),
    .req_flash(req_flash), .req_code(req_code), .req_shutdown(req_shutdown), .busy(busy));
  led_link_monitor #(.OFF_CYC(DEV_OFF)) u_led_link_monitor (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .backlight_serial_line(u_led_link_if.backlight_serial_line),
    .flash_serial_line(u_led_link_if.flash_serial_line),
    .timer_cap_grounded(timer_cap_grounded), .backlight_sink_at_pump(backlight_sink_at_pump),
    .backlight_code(backlight_code), .flash_code(flash_code),
    .backlight_sinks(backlight_sinks), .flash_timer_run(flash_timer_run),
    .shutdown(shutdown));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one host request, then wait out busy under a bound
  task automatic send(input logic fl, input code_t code, input logic sd);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_flash = fl;
    req_code = code;
    req_shutdown = sd;
    step(1);
    req_valid = 1'b0;
    check({4'h0, busy}, 5'h01);
    while (busy === 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    // a busy that never falls is counted here as a mismatch
    check({4'h0, busy}, 5'h00);
    step(4);
  endtask : send
  // lowest level, full scale and a middle level back to back
  task automatic t_levels();
    code_t c[3] = '{5'h10, 5'h01, 5'h07};
    foreach (c[i]) begin
      send(1'b0, c[i], 1'b0);
      check(backlight_code, c[i]);
      check(flash_code, 5'h00);
    end
    check({1'b0, backlight_sinks}, 5'h0f);
  endtask : t_levels
  // timer runs with a live capacitor and ends the flash
  task automatic t_flash();
    send(1'b1, 5'h05, 1'b0);
    check(flash_code, 5'h05);
    check({4'h0, flash_timer_run}, 5'h01);
    step(FL_CYC + 10);
    check(flash_code, 5'h00);
    check({1'b0, flash_sinks}, 5'h00);
  endtask : t_flash
  // grounded capacitor: flash stays on past the timer length
  task automatic t_ground();
    timer_cap_grounded = 1'b1;
    step(4);
    send(1'b1, 5'h10, 1'b0);
    step(FL_CYC + 10);
    check(flash_code, 5'h10);
    check({1'b0, flash_sinks}, 5'h0f);
    check({4'h0, flash_timer_run}, 5'h00);
  endtask : t_ground
  task automatic t_sink();
    backlight_sink_at_pump = 4'h5;
    flash_sink_at_pump = 4'h3;
    step(6);
    check({1'b0, backlight_sinks}, 5'h0a);
    check({1'b0, flash_sinks}, 5'h0c);
  endtask : t_sink
  // both lines dropped: shutdown and cleared codes
  task automatic t_shut();
    send(1'b0, 5'h01, 1'b1);
    step(8);
    check({4'h0, shutdown}, 5'h01);
    check(backlight_code, 5'h00);
    check(flash_code, 5'h00);
  endtask : t_shut
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    step(8);
    sys_rst = 1'b0;
    t_levels();
    t_flash();
    t_ground();
    t_sink();
    t_shut();
    close_out();
  end
endmodule : edge_count_led_current_ctrl_tb_top

// *** led_link_device.sv ***
// device end: edge counting, latching, flash timer, shutdown and sink control
`timescale 1ns/1ps
module led_link_device #(
  parameter int unsigned LATCH_CYC = led_link_pkg::LATCH_HOLD_CYC,
  parameter int unsigned OFF_CYC = led_link_pkg::OFF_TIMEOUT_CYC,
  parameter int unsigned FLASH_CYC = led_link_pkg::FLASH_TIME_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  led_link_if.device link,
  input wire logic timer_cap_grounded,
  input wire logic [led_link_pkg::SINKS-1:0] backlight_sink_at_pump,
  input wire logic [led_link_pkg::SINKS-1:0] flash_sink_at_pump,
  output logic [led_link_pkg::CODE_W-1:0] backlight_code,
  output logic [led_link_pkg::CODE_W-1:0] flash_code,
  output logic [led_link_pkg::SINKS-1:0] backlight_sinks,
  output logic [led_link_pkg::SINKS-1:0] flash_sinks,
  output logic flash_timer_run,
  output logic shutdown
);
  import led_link_pkg::*;

  // synchronisers for pins: lines, timing-cap sense, sink sense
  logic [1:0] ln_s1_q, ln_s2_q, ln_s3_q;
  logic cap_s1_q, cap_s2_q;
  logic [2*SINKS-1:0] pump_s1_q, pump_s2_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ln_s1_q <= 2'h0;
      ln_s2_q <= 2'h0;
      ln_s3_q <= 2'h0;
      cap_s1_q <= 1'h0;
      cap_s2_q <= 1'h0;
      pump_s1_q <= '0;
      pump_s2_q <= '0;
    end else begin
      ln_s1_q <= {link.flash_serial_line, link.backlight_serial_line};
      ln_s2_q <= ln_s1_q;
      ln_s3_q <= ln_s2_q; // edge detector reads only stage two onward
      cap_s1_q <= timer_cap_grounded;
      cap_s2_q <= cap_s1_q;
      pump_s1_q <= {flash_sink_at_pump, backlight_sink_at_pump};
      pump_s2_q <= pump_s1_q;
    end
  end

  // one edge counter per section; index 0 backlight, 1 flash
  logic [CODE_W-1:0] cnt_q [2];
  logic [CODE_W-1:0] cnt_d [2];
  logic [CODE_W-1:0] code_q [2];
  logic [CODE_W-1:0] code_d [2];
  logic [CNT_W-1:0] hi_q [2];
  logic [CNT_W-1:0] hi_d [2];
  logic [1:0] latch_now;
  logic [CNT_W-1:0] off_q, off_d;
  logic shut_q, shut_d;

  // shutdown: both lines low past the off timeout
  always_comb begin
    off_d = off_q;
    shut_d = shut_q;
    if (ln_s2_q != 2'h0) begin
      off_d = '0;
      shut_d = 1'b0;
    end else if (off_q >= CNT_W'(OFF_CYC)) begin
      shut_d = 1'b1;
    end else begin
      off_d = off_q + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sec
      // count rising edges, latch after a long enough high level
      always_comb begin
        cnt_d[g] = cnt_q[g];
        code_d[g] = code_q[g];
        hi_d[g] = hi_q[g];
        latch_now[g] = 1'b0;
        if (shut_q) begin
          cnt_d[g] = CODE_OFF;
          code_d[g] = CODE_OFF;
          hi_d[g] = '0;
        end else if (ln_s2_q[g] && !ln_s3_q[g]) begin
          // edges are seen at any rate up to half the sampling clock
          if (cnt_q[g] < CODE_MAX) begin
            cnt_d[g] = cnt_q[g] + 1'b1;
          end
          hi_d[g] = '0;
        end else if (ln_s2_q[g]) begin
          if (hi_q[g] == CNT_W'(LATCH_CYC - 1)) begin
            // hold time below 500 us commits the count
            if (cnt_q[g] != CODE_OFF) begin
              code_d[g] = cnt_q[g];
              latch_now[g] = 1'b1;
            end
            cnt_d[g] = CODE_OFF;
            hi_d[g] = hi_q[g] + 1'b1;
          end else if (hi_q[g] < CNT_W'(LATCH_CYC)) begin
            hi_d[g] = hi_q[g] + 1'b1;
          end
        end else begin
          hi_d[g] = '0;
        end
      end

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_q[g] <= CODE_OFF;
          code_q[g] <= CODE_OFF;
          hi_q[g] <= '0;
        end else begin
          cnt_q[g] <= cnt_d[g];
          code_q[g] <= code_d[g];
          hi_q[g] <= hi_d[g];
        end
      end
    end
  endgenerate

  // flash timer: restarted by every new flash level, gated by cap sense
  logic [31:0] ft_q, ft_d;
  logic frun_q, frun_d;
  logic fexp_q, fexp_d;
  always_comb begin
    ft_d = ft_q;
    frun_d = frun_q;
    fexp_d = fexp_q;
    if (shut_q) begin
      ft_d = '0;
      frun_d = 1'b0;
      fexp_d = 1'b0;
    end else if (latch_now[1]) begin
      ft_d = '0;
      frun_d = 1'b1;
      fexp_d = 1'b0; // new level re-arms the sinks
    end else if (frun_q && !cap_s2_q) begin
      if (ft_q >= FLASH_CYC - 1) begin
        frun_d = 1'b0;
        fexp_d = 1'b1;
      end else begin
        ft_d = ft_q + 1'b1;
      end
    end else if (cap_s2_q) begin
      frun_d = 1'b0; // grounded cap never expires
    end
  end

  // outputs registered; code index 1 is full scale, 16 the lowest
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      off_q <= '0;
      shut_q <= 1'b0;
      ft_q <= '0;
      frun_q <= 1'b0;
      fexp_q <= 1'b0;
      backlight_code <= CODE_OFF;
      flash_code <= CODE_OFF;
      backlight_sinks <= '0;
      flash_sinks <= '0;
      flash_timer_run <= 1'b0;
      shutdown <= 1'b0;
    end else begin
      off_q <= off_d;
      shut_q <= shut_d;
      ft_q <= ft_d;
      frun_q <= frun_d;
      fexp_q <= fexp_d;
      backlight_code <= code_q[0];
      flash_code <= fexp_q ? CODE_OFF : code_q[1];
      // unused or shorted sinks stay off
      backlight_sinks <= (code_q[0] != CODE_OFF) ? ~pump_s2_q[SINKS-1:0] : '0;
      flash_sinks <= (code_q[1] != CODE_OFF && !fexp_q) ? ~pump_s2_q[2*SINKS-1:SINKS] : '0;
      flash_timer_run <= frun_q;
      shutdown <= shut_q;
    end
  end
endmodule : led_link_device

// *** led_link_host.sv ***
// host end: turns a requested code into edges, hold-high latch, or shutdown
`timescale 1ns/1ps
module led_link_host #(
  parameter int unsigned PHASE_CYC = led_link_pkg::HOST_PHASE_CYC,
  parameter int unsigned LATCH_CYC = led_link_pkg::HOST_LATCH_CYC,
  parameter int unsigned OFF_CYC = led_link_pkg::HOST_LATCH_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  led_link_if.host link,
  input wire logic req_valid,
  input wire logic req_flash,
  input wire logic [led_link_pkg::CODE_W-1:0] req_code,
  input wire logic req_shutdown,
  output logic busy
);
  import led_link_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW = 5'h02,
    ST_HIGH = 5'h04,
    ST_HOLD = 5'h08,
    ST_OFF = 5'h10
  } host_e;

  host_e st_q, st_d;
  logic [CODE_W-1:0] left_q, left_d;
  logic [CNT_W-1:0] tm_q, tm_d;
  logic sel_q, sel_d;
  logic [1:0] line_q, line_d;
  logic busy_d;

  // shutdown request drops both lines past the off timeout; a code 0 request is ignored
  always_comb begin
    st_d = st_q;
    left_d = left_q;
    tm_d = tm_q + 1'b1;
    sel_d = sel_q;
    line_d = line_q;
    case (st_q)
      ST_IDLE: begin
        tm_d = '0;
        if (req_valid && req_shutdown) begin
          line_d = 2'h0;
          st_d = ST_OFF;
        end else if (req_valid && req_code != CODE_OFF && req_code <= CODE_MAX) begin
          sel_d = req_flash;
          left_d = req_code; // full count every time
          line_d[req_flash] = 1'b0;
          st_d = ST_LOW;
        end
      end
      ST_LOW: if (tm_q >= CNT_W'(PHASE_CYC - 1)) begin
        tm_d = '0;
        line_d[sel_q] = 1'b1; // one rising edge per step
        left_d = left_q - 1'b1;
        st_d = (left_q == 5'h01) ? ST_HOLD : ST_HIGH;
      end
      ST_HIGH: if (tm_q >= CNT_W'(PHASE_CYC - 1)) begin
        tm_d = '0;
        line_d[sel_q] = 1'b0;
        st_d = ST_LOW;
      end
      ST_HOLD: if (tm_q >= CNT_W'(LATCH_CYC - 1)) begin
        st_d = ST_IDLE; // line stays high so the code latches
      end
      ST_OFF: if (tm_q >= CNT_W'(OFF_CYC - 1)) begin
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  // line registers drive the pins straight from flip-flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      left_q <= CODE_OFF;
      tm_q <= '0;
      sel_q <= 1'b0;
      line_q <= 2'h0;
      busy <= 1'b0;
    end else begin
      st_q <= st_d;
      left_q <= left_d;
      tm_q <= tm_d;
      sel_q <= sel_d;
      line_q <= line_d;
      busy <= busy_d;
    end
  end

  assign link.backlight_serial_line = line_q[0];
  assign link.flash_serial_line = line_q[1];
endmodule : led_link_host

// *** led_link_if.sv ***
// two serial set lines between host and device
`timescale 1ns/1ps
interface led_link_if;
  logic backlight_serial_line;
  logic flash_serial_line;
  modport host (output backlight_serial_line, output flash_serial_line);
  modport device (input backlight_serial_line, input flash_serial_line);
endinterface : led_link_if

// *** led_link_monitor.sv ***
// concurrent checks on the two set lines and the device outputs
`timescale 1ns/1ps
module led_link_monitor #(
  parameter int unsigned OFF_CYC = led_link_pkg::OFF_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic backlight_serial_line,
  input wire logic flash_serial_line,
  input wire logic timer_cap_grounded,
  input wire logic [led_link_pkg::SINKS-1:0] backlight_sink_at_pump,
  input wire logic [led_link_pkg::CODE_W-1:0] backlight_code,
  input wire logic [led_link_pkg::CODE_W-1:0] flash_code,
  input wire logic [led_link_pkg::SINKS-1:0] backlight_sinks,
  input wire logic flash_timer_run,
  input wire logic shutdown
);
  import led_link_pkg::*;
  logic [CNT_W-1:0] low_run_q;
  logic [CNT_W-1:0] low_run_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // both-low run length; saturates so a long shutdown never wraps
  always_comb begin
    low_run_d = low_run_q;
    if (backlight_serial_line || flash_serial_line) low_run_d = '0;
    else if (low_run_q != '1) low_run_d = low_run_q + 1'b1;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) low_run_q <= '0;
    else low_run_q <= low_run_d;
  end
  bl_code_range_a: assert property (backlight_code <= CODE_MAX)
    else $error("backlight code above top level");
  fl_code_range_a: assert property (flash_code <= CODE_MAX)
    else $error("flash code above top level");
  bl_latch_high_a: assert property (
    ($changed(backlight_code) && backlight_code != CODE_OFF && !shutdown)
    |-> $past(backlight_serial_line, 4)) else $error("backlight latched without high");
  fl_latch_high_a: assert property (
    ($changed(flash_code) && flash_code != CODE_OFF && !shutdown)
    |-> $past(flash_serial_line, 4)) else $error("flash latched without high");
  shut_entry_a: assert property ($rose(shutdown) |-> low_run_q >= CNT_W'(OFF_CYC))
    else $error("shutdown before off timeout");
  shut_bound_a: assert property ((low_run_q == CNT_W'(OFF_CYC + 6)) |-> shutdown)
    else $error("no shutdown after long low");
  shut_clear_a: assert property ($rose(shutdown)
    |-> ##1 (backlight_code == CODE_OFF && flash_code == CODE_OFF))
    else $error("codes kept in shutdown");
  sink_off_a: assert property (($stable(backlight_sink_at_pump))[*5]
    |-> (backlight_sinks & backlight_sink_at_pump) == '0) else $error("sink at pump on");
  timer_start_a: assert property (
    ($changed(flash_code) && flash_code != CODE_OFF && !timer_cap_grounded)
    |-> ##[0:2] flash_timer_run) else $error("flash timer not started");
endmodule : led_link_monitor

// *** led_link_pkg.sv ***
// constants and types shared by both ends of the edge-count current link
package led_link_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned LEVELS = 16;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned SINKS = 4;
  // device latches well inside the 500 us limit; timeout uses the full figure
  localparam int unsigned LATCH_HOLD_US = 400;
  localparam int unsigned OFF_TIMEOUT_US = 500;
  localparam int unsigned LATCH_HOLD_CYC = LATCH_HOLD_US * 1000 / CLK_NS;
  localparam int unsigned OFF_TIMEOUT_CYC = (OFF_TIMEOUT_US * 1000 + CLK_NS - 1) / CLK_NS;
  // host pulse timing: 1 us high and low, well inside the 75 us window
  localparam int unsigned HOST_PHASE_NS = 1000;
  localparam int unsigned HOST_PHASE_CYC = (HOST_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOST_LATCH_US = 600;
  localparam int unsigned HOST_LATCH_CYC = (HOST_LATCH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned FLASH_TIME_CYC = 25_000_000;
  localparam logic [CODE_W-1:0] CODE_OFF = 5'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h10;
  typedef logic [CODE_W-1:0] code_t;
endpackage : led_link_pkg
